// ### core/pgen_bar.sv
// Bar sequencer: tracks the bar and byte position within an active line.
// Assumes start pulses once per line before the first byte is taken.
module pgen_bar
  import pgen_pkg::*;
(
  // Clock and control
  input  wire logic        mclk,
  input  wire logic        rst_s_b,
  input  wire logic        clk_en,
  // Line control
  input  wire logic        start,
  input  wire logic        adv,
  input  wire logic [15:0] bar_width,
  input  wire logic [1:0]  bar_code,
  // Current byte value
  output logic      [7:0]  bar_byte
);
  logic [15:0] cnt_r, cnt_nxt;  // Bytes sent in current bar
  logic [2:0]  idx_r, idx_nxt;  // Current bar
  logic [7:0]  val_r, val_nxt;  // Byte value of current bar
  logic [2:0]  last_idx;        // Last bar of the line

  // Bar count 1, 2, 4 or 8 from a 2-bit code
  assign last_idx = 3'((4'h1 << bar_code) - 4'h1);  // [RQ14]

  // Advance through the bars
  always_comb begin
    cnt_nxt = cnt_r;
    idx_nxt = idx_r;
    val_nxt = val_r;
    if (start) begin
      cnt_nxt = 16'h0000;
      idx_nxt = 3'h0;
      val_nxt = BAR_VALUES[0];
    end else if (adv) begin
      if ((17'(cnt_r) + 17'h1 >= 17'(bar_width)) && (idx_r < last_idx)) begin  // [RQ7]
        cnt_nxt = 16'h0000;
        idx_nxt = idx_r + 3'h1;
        val_nxt = BAR_VALUES[idx_r + 3'h1];  // [RQ13]
      end else begin
        cnt_nxt = (cnt_r == 16'hffff) ? cnt_r : cnt_r + 16'h1;  // Last bar fills the rest
      end
    end
  end

  // Register the bar state
  always_ff @(posedge mclk or negedge rst_s_b) begin
    if (!rst_s_b) begin
      cnt_r <= 16'h0000;
      idx_r <= 3'h0;
      val_r <= BAR_VALUES[0];
    end else if (clk_en) begin
      cnt_r <= cnt_nxt;
      idx_r <= idx_nxt;
      val_r <= val_nxt;
    end
  end

  assign bar_byte = val_r;

  // Value holds inside a bar
  chk_bar_hold: assert property (@(posedge mclk) disable iff (!rst_s_b)
    clk_en && adv && !start && (17'(cnt_r) + 17'h1 < 17'(bar_width)) |=> $stable(val_r))  // [RQ7]
    else $error("bar value changed inside bar");
  // Value always matches the table entry of the bar
  chk_bar_table: assert property (@(posedge mclk) disable iff (!rst_s_b)
    val_r == BAR_VALUES[idx_r] && idx_r <= 3'h7)  // [RQ13]
    else $error("bar value off table");
  // Bar index stays within the selected count
  chk_bar_limit: assert property (@(posedge mclk) disable iff (!rst_s_b)
    clk_en && adv && !start && idx_r >= last_idx |=> idx_r == $past(idx_r))  // [RQ14]
    else $error("bar index past last bar");
endmodule // pgen_bar

// ### core/pgen_pkg.sv
// Constants, types and the bar table shared by the pattern generator files.
// Assumes a 50 MHz clock and an 8-bit register port at the device's main offsets.
// Requirements
// [RQ1] Emit exactly the programmed active lines per frame
// [RQ2] Repeat frames of the programmed total line count
// [RQ3] Active line length is a programmed byte count
// [RQ4] Back-porch blank lines follow frame start
// [RQ5] Front-porch blank lines precede frame end
// [RQ6] Every line paced by period in 10 ns
// [RQ7] Next bar value after bar-width bytes
// [RQ8] Headers carry programmed data type and channel
// [RQ9] Software derives bar width from line blocks
// [RQ10] Software keeps bar width block aligned
// [RQ11] Settings reached through select, address, data window
// [RQ12] Period unit is 20 ns in 400M mode
// [RQ13] Eight bars use the fixed byte values
// [RQ14] Bar count selectable as 1, 2, 4, 8
// [RQ15] Frame: start, porch, active, blanking, end
// [RQ16] Wide settings split, high byte lower offset
package pgen_pkg;
  // Main register offsets of the indirect window
  localparam logic [7:0] ADDR_PAGE_SEL = 8'hb0;  // Page select
  localparam logic [7:0] ADDR_IND_ADDR = 8'hb1;  // Indirect offset
  localparam logic [7:0] ADDR_IND_DATA = 8'hb2;  // Indirect data
  // Page field inside the select register
  localparam int         PAGE_LSB      = 2;
  localparam int         PAGE_MSB      = 5;
  localparam logic [3:0] PAGE_PGEN     = 4'h0;  // Pattern generator page
  // Indirect offsets of the pattern generator page
  localparam logic [3:0] IDX_CONTROL   = 4'h1;
  localparam logic [3:0] IDX_CONFIG    = 4'h2;
  localparam logic [3:0] IDX_DI        = 4'h3;
  localparam logic [3:0] IDX_LINE_HI   = 4'h4;
  localparam logic [3:0] IDX_LINE_LO   = 4'h5;
  localparam logic [3:0] IDX_BAR_HI    = 4'h6;
  localparam logic [3:0] IDX_BAR_LO    = 4'h7;
  localparam logic [3:0] IDX_ACT_HI    = 4'h8;
  localparam logic [3:0] IDX_ACT_LO    = 4'h9;
  localparam logic [3:0] IDX_TOT_HI    = 4'ha;
  localparam logic [3:0] IDX_TOT_LO    = 4'hb;
  localparam logic [3:0] IDX_PD_HI     = 4'hc;
  localparam logic [3:0] IDX_PD_LO     = 4'hd;
  localparam logic [3:0] IDX_VBP       = 4'he;
  localparam logic [3:0] IDX_VFP       = 4'hf;
  localparam logic [3:0] IDX_FIRST     = 4'h1;
  localparam logic [7:0] IDX_LIMIT     = 8'h0f;  // Highest mapped offset
  localparam logic [7:0] PGEN_REG_RESET = 8'h00;  // Reset value of every setting
  // Field positions
  localparam int         CTL_ENABLE_BIT = 0;  // Control: generator enable
  localparam int         CFG_BARS_LSB   = 0;  // Config: bar count code, 2 bits
  localparam int         DI_VC_LSB      = 6;  // Identifier: channel [7:6]
  localparam int         DI_DT_MSB      = 5;  // Identifier: data type [5:0]
  // CSI-2 short packet data types
  localparam logic [5:0] DT_FRAME_START = 6'h00;
  localparam logic [5:0] DT_FRAME_END   = 6'h01;
  // Bar byte values, first to last
  localparam logic [7:0] BAR_VALUES [8] = '{8'haa, 8'h33, 8'hf0, 8'h7f,
                                            8'h55, 8'hcc, 8'h0f, 8'h80};
  // Line period timing
  localparam int         CLK_PERIOD_NS = 20;  // 50 MHz
  localparam int         UNIT_NS       = 10;  // Normal unit
  localparam int         UNIT_400M_NS  = 20;  // Unit in 400M lane mode
  localparam logic [16:0] STEP_NORMAL  = 17'(CLK_PERIOD_NS / UNIT_NS);
  localparam logic [16:0] STEP_400M    = 17'(CLK_PERIOD_NS / UNIT_400M_NS);
  // Frame sequencer states
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_FS   = 6'b000010,
    S_HDR  = 6'b000100,
    S_DATA = 6'b001000,
    S_WAIT = 6'b010000,
    S_FE   = 6'b100000
  } pgen_state_t;
endpackage

// ### core/pgen_regs.sv
// Indirect register window and the pattern generator settings page.
// Assumes one-cycle read and write strobes, synchronous to mclk.
module pgen_regs
  import pgen_pkg::*;
(
  // Clock and control
  input  wire logic        mclk,
  input  wire logic        rst_s_b,
  input  wire logic        clk_en,
  // Register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  // Settings
  output logic      [7:0]  ctl,
  output logic      [7:0]  cfg,
  output logic      [7:0]  di,
  output logic      [15:0] line_bytes,
  output logic      [15:0] bar_width,
  output logic      [15:0] act_lines,
  output logic      [15:0] tot_lines,
  output logic      [15:0] line_period,
  output logic      [7:0]  vbp,
  output logic      [7:0]  vfp
);
  logic [7:0] sel_r, sel_nxt;          // Page select
  logic [7:0] idx_r, idx_nxt;          // Indirect offset
  logic [7:0] mem_r [16];              // Settings page
  logic [7:0] mem_nxt [16];
  logic [7:0] rdata_r, rdata_nxt;
  logic       rvalid_r, rvalid_nxt;

  // Window hits a mapped pattern generator setting
  function automatic logic page_hit(input logic [7:0] sel, input logic [7:0] idx);
    page_hit = (sel[PAGE_MSB:PAGE_LSB] == PAGE_PGEN) && (idx >= 8'(IDX_FIRST))
               && (idx <= IDX_LIMIT);
  endfunction

  // Next values of the window and the page
  always_comb begin
    sel_nxt    = sel_r;
    idx_nxt    = idx_r;
    mem_nxt    = mem_r;
    rdata_nxt  = rdata_r;
    rvalid_nxt = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_PAGE_SEL: sel_nxt = reg_wdata;
        ADDR_IND_ADDR: idx_nxt = reg_wdata;
        ADDR_IND_DATA: begin
          if (page_hit(sel_r, idx_r)) begin  // [RQ11]
            mem_nxt[idx_r[3:0]] = reg_wdata;
          end
        end
        default: ;  // Not ours
      endcase
    end
    if (reg_rd) begin
      rvalid_nxt = 1'b1;
      case (reg_addr)
        ADDR_PAGE_SEL: rdata_nxt = sel_r;
        ADDR_IND_ADDR: rdata_nxt = idx_r;
        ADDR_IND_DATA: rdata_nxt = page_hit(sel_r, idx_r) ? mem_r[idx_r[3:0]] : 8'h00;
        default:       rdata_nxt = 8'h00;  // Unmapped reads as zero
      endcase
    end
  end

  // Register the window
  always_ff @(posedge mclk or negedge rst_s_b) begin
    if (!rst_s_b) begin
      sel_r    <= PGEN_REG_RESET;
      idx_r    <= PGEN_REG_RESET;
      mem_r    <= '{default: PGEN_REG_RESET};
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else if (clk_en) begin
      sel_r    <= sel_nxt;
      idx_r    <= idx_nxt;
      mem_r    <= mem_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // Settings out, high byte at the lower offset
  assign reg_rdata   = rdata_r;
  assign reg_rvalid  = rvalid_r;
  assign ctl         = mem_r[IDX_CONTROL];
  assign cfg         = mem_r[IDX_CONFIG];
  assign di          = mem_r[IDX_DI];
  assign line_bytes  = {mem_r[IDX_LINE_HI], mem_r[IDX_LINE_LO]};  // [RQ16]
  assign bar_width   = {mem_r[IDX_BAR_HI], mem_r[IDX_BAR_LO]};    // [RQ16]
  assign act_lines   = {mem_r[IDX_ACT_HI], mem_r[IDX_ACT_LO]};    // [RQ16]
  assign tot_lines   = {mem_r[IDX_TOT_HI], mem_r[IDX_TOT_LO]};    // [RQ16]
  assign line_period = {mem_r[IDX_PD_HI], mem_r[IDX_PD_LO]};      // [RQ16]
  assign vbp         = mem_r[IDX_VBP];
  assign vfp         = mem_r[IDX_VFP];

  // Data written through the window lands in the page
  chk_window_write: assert property (@(posedge mclk) disable iff (!rst_s_b)
    clk_en && reg_wr && reg_addr == ADDR_IND_DATA && page_hit(sel_r, idx_r)
    |=> mem_r[4'($past(idx_r))] == $past(reg_wdata))  // [RQ11]
    else $error("indirect write lost");
endmodule // pgen_regs

// ### core/pgen_top.sv
// Colour bar pattern generator: frame sequencer, line timer and packet outputs.
// Assumes the CSI-2 transmitter takes headers and bytes on valid and ready.
module pgen_top
  import pgen_pkg::*;
(
  // Clock, reset and freeze
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  // Register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  // Transmitter mode
  input  wire logic        lane_400m,
  // Packet header output
  output logic             hdr_valid,
  input  wire logic        hdr_ready,
  output logic      [5:0]  hdr_dt,
  output logic      [1:0]  hdr_vc,
  output logic      [15:0] hdr_wc,
  // Payload byte output
  output logic             byte_valid,
  input  wire logic        byte_ready,
  output logic      [7:0]  byte_data,
  output logic             byte_last,
  // Status
  output logic             frame_busy
);
  logic        rst_m_r, rst_s_b;  // Reset synchroniser
  logic [7:0]  ctl, cfg, di, vbp, vfp;
  logic [15:0] line_bytes, bar_width, act_lines, tot_lines, line_period;

  // Release reset through two flops
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_r <= 1'b0;
      rst_s_b <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_s_b <= rst_m_r;
    end
  end

  // Settings page
  pgen_regs u_regs (
    .mclk        (mclk),
    .rst_s_b     (rst_s_b),
    .clk_en      (clk_en),
    .reg_wr      (reg_wr),
    .reg_rd      (reg_rd),
    .reg_addr    (reg_addr),
    .reg_wdata   (reg_wdata),
    .reg_rdata   (reg_rdata),
    .reg_rvalid  (reg_rvalid),
    .ctl         (ctl),
    .cfg         (cfg),
    .di          (di),
    .line_bytes  (line_bytes),
    .bar_width   (bar_width),
    .act_lines   (act_lines),
    .tot_lines   (tot_lines),
    .line_period (line_period),
    .vbp         (vbp),
    .vfp         (vfp)
  );

  pgen_state_t st_r, st_nxt;            // Frame sequencer
  logic [16:0] line_r, line_nxt;        // Line within frame
  logic [15:0] byte_r, byte_nxt;        // Byte within line
  logic        hval_r, hval_nxt;        // Header valid
  logic [5:0]  hdt_r, hdt_nxt;          // Header data type
  logic [15:0] hwc_r, hwc_nxt;          // Header word count
  logic        bval_r, bval_nxt;        // Byte valid
  logic        blast_r, blast_nxt;      // Last byte of line
  logic        bar_start;               // Restart bars
  logic        hdr_take, byte_take;     // Handshakes
  logic [16:0] tmr_r, tmr_nxt;          // Line period timer
  logic        pend_r, pend_nxt;        // Line period elapsed
  logic [16:0] tmr_step, tmr_sum;
  logic        line_tick, pend_use;
  logic [16:0] vsum, frame_len, frame_end;

  assign hdr_take  = hval_r && hdr_ready;
  assign byte_take = bval_r && byte_ready;

  // Frame length covers total lines and at least porches plus active
  assign vsum      = 17'(vbp) + 17'(act_lines) + 17'(vfp);
  assign frame_len = (vsum > 17'(tot_lines)) ? vsum : 17'(tot_lines);  // [RQ2] [RQ5]
  assign frame_end = (frame_len == 17'h0) ? 17'h0 : frame_len - 17'h1;

  // Line carries pattern data
  function automatic logic is_active(input logic [16:0] l, input logic [7:0] bp,
                                     input logic [15:0] act);
    is_active = (l >= 17'(bp)) && (l < 17'(bp) + 17'(act));  // [RQ1] [RQ4]
  endfunction

  // Line timer: clock period expressed in period units
  assign tmr_step  = lane_400m ? STEP_400M : STEP_NORMAL;  // [RQ6] [RQ12]
  assign tmr_sum   = tmr_r + tmr_step;
  assign line_tick = (st_r != S_IDLE) && (tmr_sum >= 17'(line_period));  // [RQ6]
  assign pend_use  = (st_r == S_WAIT) && pend_r;

  // Timer and elapsed flag, a new tick wins over the consume
  always_comb begin
    tmr_nxt  = tmr_sum;
    pend_nxt = line_tick || (pend_r && !pend_use);
    if (st_r == S_IDLE) begin
      tmr_nxt  = 17'h0;
      pend_nxt = 1'b0;
    end else if (line_tick) begin
      tmr_nxt  = 17'h0;
    end
  end

  always_ff @(posedge mclk or negedge rst_s_b) begin
    if (!rst_s_b) begin
      tmr_r  <= 17'h0;
      pend_r <= 1'b0;
    end else if (clk_en) begin
      tmr_r  <= tmr_nxt;
      pend_r <= pend_nxt;
    end
  end

  // Frame sequencer: start, lines, end
  always_comb begin
    st_nxt    = st_r;
    line_nxt  = line_r;
    byte_nxt  = byte_r;
    hval_nxt  = hval_r;
    hdt_nxt   = hdt_r;
    hwc_nxt   = hwc_r;
    bval_nxt  = bval_r;
    blast_nxt = blast_r;
    bar_start = 1'b0;
    case (st_r)
      S_IDLE: begin
        if (ctl[CTL_ENABLE_BIT]) begin  // [RQ15]
          st_nxt   = S_FS;
          line_nxt = 17'h0;
          hval_nxt = 1'b1;
          hdt_nxt  = DT_FRAME_START;
          hwc_nxt  = 16'h0000;
        end
      end
      S_FS: begin
        if (hdr_take) begin
          hval_nxt = 1'b0;
          st_nxt   = S_WAIT;
          if (is_active(line_r, vbp, act_lines)) begin
            st_nxt   = S_HDR;
            hval_nxt = 1'b1;
            hdt_nxt  = di[DI_DT_MSB:0];  // [RQ8]
            hwc_nxt  = line_bytes;       // [RQ3]
          end
        end
      end
      S_HDR: begin
        if (hdr_take) begin
          hval_nxt  = 1'b0;
          bar_start = 1'b1;
          byte_nxt  = 16'h0000;
          if (line_bytes == 16'h0000) begin
            st_nxt = S_WAIT;
          end else begin
            st_nxt    = S_DATA;
            bval_nxt  = 1'b1;
            blast_nxt = (line_bytes == 16'h0001);
          end
        end
      end
      S_DATA: begin
        if (byte_take) begin
          if (blast_r) begin  // [RQ3]
            bval_nxt  = 1'b0;
            blast_nxt = 1'b0;
            st_nxt    = S_WAIT;
          end else begin
            byte_nxt  = byte_r + 16'h1;
            blast_nxt = (17'(byte_r) + 17'h2 >= 17'(line_bytes));
          end
        end
      end
      S_WAIT: begin
        if (pend_r) begin
          if (line_r >= frame_end) begin  // [RQ2] [RQ15]
            st_nxt   = S_FE;
            hval_nxt = 1'b1;
            hdt_nxt  = DT_FRAME_END;
            hwc_nxt  = 16'h0000;
          end else begin
            line_nxt = line_r + 17'h1;
            if (is_active(line_r + 17'h1, vbp, act_lines)) begin  // [RQ1]
              st_nxt   = S_HDR;
              hval_nxt = 1'b1;
              hdt_nxt  = di[DI_DT_MSB:0];
              hwc_nxt  = line_bytes;
            end
          end
        end
      end
      S_FE: begin
        if (hdr_take) begin
          hval_nxt = ctl[CTL_ENABLE_BIT];  // Next frame follows at once
          st_nxt   = ctl[CTL_ENABLE_BIT] ? S_FS : S_IDLE;
          hdt_nxt  = DT_FRAME_START;
          line_nxt = 17'h0;
        end
      end
      default: begin
        st_nxt   = S_IDLE;
        hval_nxt = 1'b0;
        bval_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_s_b) begin
    if (!rst_s_b) begin
      st_r    <= S_IDLE;
      line_r  <= 17'h0;
      byte_r  <= 16'h0000;
      hval_r  <= 1'b0;
      hdt_r   <= DT_FRAME_START;
      hwc_r   <= 16'h0000;
      bval_r  <= 1'b0;
      blast_r <= 1'b0;
    end else if (clk_en) begin
      st_r    <= st_nxt;
      line_r  <= line_nxt;
      byte_r  <= byte_nxt;
      hval_r  <= hval_nxt;
      hdt_r   <= hdt_nxt;
      hwc_r   <= hwc_nxt;
      bval_r  <= bval_nxt;
      blast_r <= blast_nxt;
    end
  end

  // Bar values for the payload
  pgen_bar u_bar (
    .mclk      (mclk),
    .rst_s_b   (rst_s_b),
    .clk_en    (clk_en),
    .start     (bar_start),
    .adv       (byte_take),
    .bar_width (bar_width),
    .bar_code  (cfg[CFG_BARS_LSB +: 2]),
    .bar_byte  (byte_data)
  );

  // Outputs
  assign hdr_valid  = hval_r;
  assign hdr_dt     = hdt_r;
  assign hdr_vc     = di[7:DI_VC_LSB];  // [RQ8]
  assign hdr_wc     = hwc_r;
  assign byte_valid = bval_r;
  assign byte_last  = blast_r;
  assign frame_busy = (st_r != S_IDLE);

  // Active headers seen in the current frame, read only by checks
  logic [16:0] act_seen_r;
  always_ff @(posedge mclk or negedge rst_s_b) begin
    if (!rst_s_b) begin
      act_seen_r <= 17'h0;
    end else if (clk_en && hdr_take) begin
      act_seen_r <= (hdt_r == DT_FRAME_START) ? 17'h0 :
                    (st_r == S_HDR) ? act_seen_r + 17'h1 : act_seen_r;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_s_b);

  sequence s_fe_taken;
    clk_en && hdr_take && st_r == S_FE;
  endsequence
  sequence s_next_frame;
    (st_r == S_FS && hdr_valid && hdr_dt == DT_FRAME_START) || st_r == S_IDLE;
  endsequence

  chk_active_count: assert property (  // [RQ1]
    s_fe_taken |-> act_seen_r == 17'(act_lines))
    else $error("active line count wrong at frame end");
  chk_frame_length: assert property (  // [RQ2]
    st_r == S_FE |-> line_r == frame_end && frame_len >= 17'(tot_lines))
    else $error("frame end at wrong line");
  chk_word_count: assert property (  // [RQ3]
    st_r == S_HDR && hdr_valid |-> hdr_wc == line_bytes)
    else $error("long header word count wrong");
  chk_last_byte: assert property (  // [RQ3]
    byte_take && byte_last |-> 17'(byte_r) + 17'h1 == 17'(line_bytes))
    else $error("line byte count wrong");
  chk_porch_blank: assert property (  // [RQ4]
    st_r == S_HDR |-> line_r >= 17'(vbp) && line_r < 17'(vbp) + 17'(act_lines))
    else $error("active line in porch");
  chk_front_porch: assert property (  // [RQ5]
    st_r == S_FE |-> line_r + 17'h1 >= vsum)
    else $error("front porch cut short");
  chk_period_step: assert property (  // [RQ6]
    clk_en && st_r != S_IDLE && !line_tick |=> tmr_r == $past(tmr_r) + $past(tmr_step))
    else $error("line timer step wrong");
  chk_unit_400m: assert property (  // [RQ12]
    tmr_step == (lane_400m ? 17'h1 : 17'h2))
    else $error("period unit wrong");
  chk_id_fields: assert property (  // [RQ8]
    st_r == S_HDR && hdr_valid |-> hdr_dt == di[DI_DT_MSB:0] && hdr_vc == di[7:DI_VC_LSB])
    else $error("header identifier wrong");
  chk_fe_then_fs: assert property (  // [RQ15]
    s_fe_taken |=> s_next_frame)
    else $error("frame end not followed by start or idle");
endmodule // pgen_top

// ### dv/pgen_rx_model.sv
// Stand-in for the downstream receiver: accepts headers and bytes.
// Assumes the generator holds valid and its data until taken.
module pgen_rx_model (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_b,
  // Offers from the generator
  input  wire logic hdr_valid,
  input  wire logic byte_valid,
  // Acceptance
  output logic      hdr_ready,
  output logic      byte_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  // Random stalls, about one cycle in four, to stretch some transfers
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hdr_ready  <= 1'b0;
      byte_ready <= 1'b0;
    end else begin
      hdr_ready  <= hdr_valid && ($urandom % 4 != 0);
      byte_ready <= byte_valid && ($urandom % 4 != 0);
    end
  end
endmodule // pgen_rx_model

// ### dv/testbench.sv
// Self-checking bench for the colour bar generator.
// Assumes the register window and stream handshake of pgen_top.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import pgen_pkg::*;
  logic        mclk, rst_b, clk_en, reg_wr, reg_rd, lane_400m;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, byte_data;
  logic        reg_rvalid, hdr_valid, hdr_ready, byte_valid, byte_ready, byte_last, frame_busy;
  logic [5:0]  hdr_dt;
  logic [1:0]  hdr_vc;
  logic [15:0] hdr_wc;
  logic [24:0] sq [$];  // Expected stream items, oldest first
  logic [7:0]  rq [$];  // Expected read data
  logic [24:0] e;
  int          mismatches, checked, cyc, t0, exp_len;
  pgen_top pgen_top_i (.mclk, .rst_b, .clk_en, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .lane_400m, .hdr_valid, .hdr_ready, .hdr_dt, .hdr_vc,
    .hdr_wc, .byte_valid, .byte_ready, .byte_data, .byte_last, .frame_busy);
  pgen_rx_model pgen_rx_model_i (.mclk, .rst_b, .hdr_valid, .byte_valid, .hdr_ready,
    .byte_ready);
  // Clock and cycle count
  always #10 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  task compare(input string nm, input logic [24:0] seen, input logic [24:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task report_and_stop;
    if (mismatches == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] x);
    rq.push_back(x);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
  task setr(input logic [7:0] idx, input logic [7:0] d);
    wr(ADDR_IND_ADDR, idx);
    wr(ADDR_IND_DATA, d);
  endtask
  // Output watcher: each result takes the oldest note
  always @(posedge mclk) begin
    if (reg_rvalid) begin
      e = rq.size() ? 25'(rq.pop_front()) : 25'h1ffffff;
      compare("read data", 25'(reg_rdata), e);
    end
    if (hdr_valid && hdr_ready) begin
      if (hdr_dt === DT_FRAME_START) t0 = cyc;
      if (hdr_dt === DT_FRAME_END)
        compare("frame length", 25'(cyc - t0 >= exp_len - 6 && cyc - t0 <= exp_len + 6), 1);
      e = sq.size() ? sq.pop_front() : 25'h1ffffff;
      compare("header", {1'b1, hdr_dt, hdr_vc, hdr_wc}, e);
    end
    if (byte_valid && byte_ready) begin
      e = sq.size() ? sq.pop_front() : 25'h1ffffff;
      compare("byte", {1'b0, 15'h0, byte_last, byte_data}, e);
    end
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    report_and_stop;
  end
  initial begin
    logic [1:0] vc;
    logic [5:0] dt;
    logic [7:0] v [14];
    int         bw, n, tot, bar;
    void'($urandom(32'ha2cd9185));
    mclk = 0; rst_b = 0; clk_en = 1; reg_wr = 0; reg_rd = 0;
    reg_addr = 0; reg_wdata = 0; lane_400m = 0; cyc = 0;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    // Reset values, unmapped offset and address, wrong page
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_IND_ADDR, 8'(i));
      rd(ADDR_IND_DATA, PGEN_REG_RESET);
    end
    rd(8'h40, 8'h00);
    wr(ADDR_PAGE_SEL, 8'h04);
    setr(8'h05, 8'h5a);
    rd(ADDR_IND_DATA, 8'h00);
    wr(ADDR_PAGE_SEL, 8'h00);
    rd(ADDR_IND_DATA, 8'h00);
    // One frame per bar count, alternating lane mode
    for (int code = 0; code < 4; code++) begin
      vc = 2'($urandom);
      dt = 6'h12 + 6'($urandom % 32);
      bw = 1 + $urandom % 4;
      n = 1 << code;
      tot = code[1] ? 5 : 3;
      lane_400m <= code[0];
      exp_len = (tot > 4 ? tot : 4) * (code[0] ? 200 : 100);
      v = '{8'(code), {vc, dt}, 8'h00, 8'h0c, 8'h00, 8'(bw), 8'h00, 8'h02,
            8'h00, 8'(tot), 8'h00, 8'hc8, 8'h01, 8'h01};
      for (int i = 0; i < 14; i++) setr(8'(i + 2), v[i]);
      wr(ADDR_IND_ADDR, 8'(IDX_DI));
      rd(ADDR_IND_DATA, {vc, dt});
      sq.push_back({1'b1, DT_FRAME_START, vc, 16'h0});
      for (int l = 0; l < 2; l++) begin
        sq.push_back({1'b1, dt, vc, 16'd12});
        for (int b = 0; b < 12; b++) begin
          bar = b / bw;
          if (bar > n - 1) bar = n - 1;
          sq.push_back({1'b0, 15'h0, b == 11, BAR_VALUES[bar]});
        end
      end
      sq.push_back({1'b1, DT_FRAME_END, vc, 16'h0});
      setr(8'(IDX_CONTROL), 8'h01);
      setr(8'(IDX_CONTROL), 8'h00);
      for (int k = 0; k < 3000 && frame_busy !== 1'b0; k++) @(posedge mclk);
      compare("busy", 25'(frame_busy), 0);
    end
    repeat (4) @(posedge mclk);
    compare("pending", 25'(sq.size() + rq.size()), 0);
    report_and_stop;
  end
endmodule // testbench
